//--- core/wdw_delay.sv
// Start-up delay counter used after every wake-up.
// Assumes start is a one-cycle pulse and len is at least one.
`timescale 1ns/1ns
`default_nettype none
module wdw_delay #(
    parameter int W = 24
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Control.
    input wire logic start,
    input wire logic [W-1:0] len,
    // Status.
    output logic busy,
    output logic done
);
    logic [W-1:0] cnt_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else if (start) begin
            cnt_q <= len;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign busy = (cnt_q != '0);
    // Done marks the last waiting cycle so that execution resumes exactly len cycles later.
    assign done = (cnt_q == {{(W-1){1'b0}}, 1'b1});
endmodule : wdw_delay
`default_nettype wire

//--- core/wdw_pkg.sv
// Types shared by the watchdog and wake-up files.
// Assumes the constants header is included by each user file.
package wdw_pkg;
    typedef enum logic [1:0] {WDW_SRC_LXT, WDW_SRC_SYSDIV4, WDW_SRC_LOW_SPEED_RC_OSC} wdw_clk_src_t;
    typedef enum logic [1:0] {WDW_RUN, WDW_SLEEP, WDW_DELAY} wdw_state_t;
    typedef enum logic [1:0] {WDW_PAIR_NONE, WDW_PAIR_HAVE1, WDW_PAIR_HAVE2} wdw_pair_t;
    typedef struct packed {
        logic clr;
        logic clr1;
        logic clr2;
        logic halt;
    } wdw_instr_t;
    typedef struct packed {
        logic full_reset;
        logic pcsp_reset;
        logic resume;
        logic take_irq;
    } wdw_act_t;
endpackage : wdw_pkg

//--- core/wdw_regs.svh
// Register offsets, field positions, reset values and timing counts of the watchdog block.
// Assumes pclk runs at 100 MHz and also stands in for the system clock of the core.
// Function
// - Sleep wakes on reset, pin, interrupt, overflow.
// - Reset wake resets all; overflow wake resets PC/SP.
// - Power-down flag: cleared by clears, set by halt.
// - Enabled pin falling edge wakes; resume after halt.
// - Disabled interrupt or full stack: resume after halt.
// - Enabled interrupt with free stack: take interrupt.
// - Interrupt already pending at halt never wakes.
// - Wake delay: reset+128, else 2 or 128.
// - Watchdog instructions do nothing while watchdog off.
// - Option on forces watchdog; else enable code decides.
// - Enable code 1010 disables, resets there; others enable.
// - Clock from crystal, sys/4 or RC; sys/4 sleeps.
// - Period is two to eight plus selector.
// - Run-mode timeout resets device, sets timeout flag.
// - Sleep timeout wakes, sets flag, resets PC/SP.
// - Counter cleared by reset pin, clears, halt.
// - Option picks single clear or paired clear.
// - Paired clear needs alternating distinct instructions.
// - Period register bits 7..3 read zero.
`ifndef WDW_REGS_SVH
`define WDW_REGS_SVH

`define WDW_OFS_PERIOD 12'h000
`define WDW_OFS_CTRL 12'h004
`define WDW_OFS_STATUS 12'h008
`define WDW_OFS_PORTWAKE 12'h00C

`define WDW_SEL_MSB 2
`define WDW_EN_MSB 3
`define WDW_ST_TO 0
`define WDW_ST_PDF 1
`define WDW_ST_ON 2
`define WDW_ST_SLEEP 3

`define WDW_SEL_RST 3'h7
`define WDW_EN_OFF 4'hA
`define WDW_PORTWAKE_RST 8'h00

`define WDW_PERIOD_MIN 16'h0100
`define WDW_CLK_MHZ 100
`define WDW_RSTD_MS 100
`define WDW_RSTD_CYC (`WDW_RSTD_MS * `WDW_CLK_MHZ * 1000)
`define WDW_SST1_CYC 2
`define WDW_SST2_CYC 128

`endif

//--- core/wdw_top.sv
// Watchdog timer with sleep wake-up control and its APB register file.
// Assumes all inputs are synchronous to pclk and tick inputs are one-cycle pulses.
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "wdw_regs.svh"
module wdw_top #(
    parameter int N_IRQ = 4,
    parameter int N_PINS = 8,
    parameter int RST_DELAY_CYC = `WDW_RSTD_CYC
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Configuration options.
    input wire logic cfg_wdt_en,
    input wire wdw_pkg::wdw_clk_src_t cfg_clk_src,
    input wire logic cfg_pair_clear,
    input wire logic cfg_crystal,
    // Slow clock ticks, one cycle each.
    input wire logic lxt_tick,
    input wire logic low_speed_rc_osc_tick,
    // Core instructions and interrupt state.
    input wire wdw_pkg::wdw_instr_t instr,
    input wire logic [N_IRQ-1:0] irq_req,
    input wire logic [N_IRQ-1:0] irq_en,
    input wire logic stack_full,
    // Pins.
    input wire logic ext_reset_n,
    input wire logic [N_PINS-1:0] wake_port_pins,
    // Results to the core.
    output wdw_pkg::wdw_act_t act,
    output logic wdt_reset,
    output logic cpu_run,
    output logic timeout_flag,
    output logic power_down_flag
);
    ////////////////////////////////////////////////////////////////////////////////
    logic [2:0] timeout_period_sel_q;
    logic [3:0] watchdog_enable_code_q;
    logic [N_PINS-1:0] port_wake_enable_q;
    logic [31:0] prdata_q;
    logic wr_en;
    logic setup_rd;
    logic addr_ok;
    logic [31:0] rd_d;

    assign wr_en = psel && penable && pwrite;
    assign setup_rd = psel && !penable;
    assign pready = psel && penable;
    assign addr_ok = (paddr == `WDW_OFS_PERIOD) || (paddr == `WDW_OFS_CTRL)
        || (paddr == `WDW_OFS_STATUS) || (paddr == `WDW_OFS_PORTWAKE);
    assign pslverr = pready && !addr_ok;
    assign prdata = prdata_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_period_sel_q <= `WDW_SEL_RST;
            watchdog_enable_code_q <= `WDW_EN_OFF;
            port_wake_enable_q <= N_PINS'(`WDW_PORTWAKE_RST);
        end else if (wr_en) begin
            unique case (paddr)
                `WDW_OFS_PERIOD: timeout_period_sel_q <= pwdata[`WDW_SEL_MSB:0];
                `WDW_OFS_CTRL: watchdog_enable_code_q <= pwdata[`WDW_EN_MSB:0];
                `WDW_OFS_PORTWAKE: port_wake_enable_q <= pwdata[N_PINS-1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    wdw_pkg::wdw_state_t state_q;
    wdw_pkg::wdw_pair_t pair_q;
    logic wdt_on;
    logic [14:0] cnt_q;
    logic [1:0] div_q;
    logic tick;
    logic [15:0] per_full;
    logic [14:0] limit;
    logic tmo_evt;
    logic clr_any;
    logic clr_hit;
    logic to_q;
    logic pdf_q;

    always_comb begin
        rd_d = 32'h0000_0000;
        unique case (paddr)
            `WDW_OFS_PERIOD: rd_d[`WDW_SEL_MSB:0] = timeout_period_sel_q;
            `WDW_OFS_CTRL: rd_d[`WDW_EN_MSB:0] = watchdog_enable_code_q;
            `WDW_OFS_STATUS: begin
                rd_d[`WDW_ST_TO] = to_q;
                rd_d[`WDW_ST_PDF] = pdf_q;
                rd_d[`WDW_ST_ON] = wdt_on;
                rd_d[`WDW_ST_SLEEP] = (state_q == wdw_pkg::WDW_SLEEP);
            end
            `WDW_OFS_PORTWAKE: rd_d[N_PINS-1:0] = port_wake_enable_q;
            default: ;
        endcase
    end

    // Read data is latched in the setup cycle so it comes from a flop in the access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup_rd) begin
            prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
        end
    end

    // The configuration option wins over the register enable code.
    assign wdt_on = cfg_wdt_en || (watchdog_enable_code_q != `WDW_EN_OFF);

    // The sys/4 divider runs on the system clock, which is stopped during sleep.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 2'h0;
        end else if (state_q != wdw_pkg::WDW_SLEEP) begin
            div_q <= div_q + 2'h1;
        end
    end

    always_comb begin
        unique case (cfg_clk_src)
            wdw_pkg::WDW_SRC_LXT: tick = lxt_tick;
            wdw_pkg::WDW_SRC_SYSDIV4: tick = (div_q == 2'h3) && (state_q != wdw_pkg::WDW_SLEEP);
            wdw_pkg::WDW_SRC_LOW_SPEED_RC_OSC: tick = low_speed_rc_osc_tick;
            default: tick = 1'b0;
        endcase
    end

    assign per_full = `WDW_PERIOD_MIN << timeout_period_sel_q;
    assign limit = 15'(per_full - 16'h0001);
    assign tmo_evt = wdt_on && tick && (cnt_q == limit);

    // Clear instructions are ignored entirely while the watchdog is off.
    assign clr_any = wdt_on && (instr.clr || instr.clr1 || instr.clr2);
    always_comb begin
        clr_hit = 1'b0;
        if (wdt_on) begin
            if (!cfg_pair_clear) begin
                clr_hit = instr.clr;
            end else begin
                clr_hit = (instr.clr2 && pair_q == wdw_pkg::WDW_PAIR_HAVE1)
                    || (instr.clr1 && pair_q == wdw_pkg::WDW_PAIR_HAVE2);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pair_q <= wdw_pkg::WDW_PAIR_NONE;
        end else if (wdt_on && cfg_pair_clear) begin
            if (clr_hit) begin
                pair_q <= wdw_pkg::WDW_PAIR_NONE;
            end else if (instr.clr1 && pair_q == wdw_pkg::WDW_PAIR_NONE) begin
                pair_q <= wdw_pkg::WDW_PAIR_HAVE1;
            end else if (instr.clr2 && pair_q == wdw_pkg::WDW_PAIR_NONE) begin
                pair_q <= wdw_pkg::WDW_PAIR_HAVE2;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 15'h0000;
        end else if (!ext_reset_n || clr_hit || tmo_evt) begin
            cnt_q <= 15'h0000;
        end else if (instr.halt && state_q == wdw_pkg::WDW_RUN) begin
            cnt_q <= 15'h0000;
        end else if (wdt_on && tick) begin
            cnt_q <= cnt_q + 15'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    logic [N_PINS-1:0] pins_prev_q;
    logic [N_PINS-1:0] pin_fall;
    logic [N_IRQ-1:0] irq_held_q;
    logic [N_IRQ-1:0] irq_wake;
    logic halt_run;
    logic in_sleep;
    logic wake_rst;
    logic wake_any;
    logic irq_take_d;
    logic take_q;
    logic wake_reset_q;
    logic dly_done;
    logic [23:0] dly_len;

    assign halt_run = instr.halt && state_q == wdw_pkg::WDW_RUN;
    assign in_sleep = state_q == wdw_pkg::WDW_SLEEP;
    assign pin_fall = pins_prev_q & ~wake_port_pins & port_wake_enable_q;
    assign irq_wake = irq_req & ~irq_held_q;
    assign wake_rst = in_sleep && !ext_reset_n;
    assign wake_any = in_sleep && (!ext_reset_n || tmo_evt || (irq_wake != '0)
        || (pin_fall != '0));
    assign irq_take_d = ((irq_wake & irq_en) != '0) && !stack_full;

    always_comb begin
        if (wake_rst) begin
            dly_len = 24'(RST_DELAY_CYC + `WDW_SST2_CYC);
        end else if (cfg_crystal) begin
            dly_len = 24'(`WDW_SST2_CYC);
        end else begin
            dly_len = 24'(`WDW_SST1_CYC);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_prev_q <= '0;
        end else begin
            pins_prev_q <= wake_port_pins;
        end
    end

    // Requests already raised when the halt runs are held off so they cannot wake.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_held_q <= '0;
        end else if (halt_run) begin
            irq_held_q <= irq_req;
        end else if (state_q == wdw_pkg::WDW_RUN) begin
            irq_held_q <= '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= wdw_pkg::WDW_RUN;
        end else begin
            unique case (state_q)
                wdw_pkg::WDW_RUN: if (halt_run) state_q <= wdw_pkg::WDW_SLEEP;
                wdw_pkg::WDW_SLEEP: if (wake_any) state_q <= wdw_pkg::WDW_DELAY;
                wdw_pkg::WDW_DELAY: if (dly_done) state_q <= wdw_pkg::WDW_RUN;
                default: state_q <= wdw_pkg::WDW_RUN;
            endcase
        end
    end

    // Resets are issued at the wake edge; resume or interrupt entry waits out the delay.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act <= '0;
            take_q <= 1'b0;
            wake_reset_q <= 1'b0;
            wdt_reset <= 1'b0;
        end else begin
            act <= '0;
            wdt_reset <= state_q == wdw_pkg::WDW_RUN && tmo_evt;
            if (wake_any) begin
                act.full_reset <= wake_rst;
                act.pcsp_reset <= !wake_rst && tmo_evt;
                take_q <= !wake_rst && !tmo_evt && irq_take_d;
                wake_reset_q <= wake_rst || tmo_evt;
            end
            if (state_q == wdw_pkg::WDW_DELAY && dly_done && !take_q && !wake_reset_q) begin
                act.resume <= 1'b1;
            end
            if (state_q == wdw_pkg::WDW_DELAY && dly_done && take_q) begin
                act.take_irq <= 1'b1;
            end
        end
    end

    wdw_delay #(
        .W(24)
    ) u_delay (
        .pclk(pclk),
        .presetn(presetn),
        .start(wake_any),
        .len(dly_len),
        .busy(),
        .done(dly_done)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // The timeout flag set wins over a clear arriving in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            to_q <= 1'b0;
        end else if (tmo_evt) begin
            to_q <= 1'b1;
        end else if (halt_run || clr_any) begin
            to_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pdf_q <= 1'b0;
        end else if (halt_run) begin
            pdf_q <= 1'b1;
        end else if (clr_any) begin
            pdf_q <= 1'b0;
        end
    end

    assign timeout_flag = to_q;
    assign power_down_flag = pdf_q;
    assign cpu_run = state_q == wdw_pkg::WDW_RUN;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_halt_pdf;
        halt_run |=> pdf_q && cnt_q == 15'h0000 && state_q == wdw_pkg::WDW_SLEEP;
    endproperty
    a_halt_pdf: assert property (p_halt_pdf) else $error("halt did not set flag");

    property p_off_nop;
        !wdt_on && !halt_run |=> $stable(pdf_q) && $stable(pair_q);
    endproperty
    a_off_nop: assert property (p_off_nop) else $error("clear acted while off");

    property p_run_tmo;
        state_q == wdw_pkg::WDW_RUN && tmo_evt |=> wdt_reset && to_q && cnt_q == 15'h0000;
    endproperty
    a_run_tmo: assert property (p_run_tmo) else $error("run timeout lost");

    property p_sleep_tmo;
        in_sleep && ext_reset_n && tmo_evt |=> act.pcsp_reset && to_q && !wdt_reset;
    endproperty
    a_sleep_tmo: assert property (p_sleep_tmo) else $error("sleep timeout wrong");

    property p_pair_repeat;
        cfg_pair_clear && pair_q == wdw_pkg::WDW_PAIR_HAVE1 && !instr.clr2 |-> !clr_hit;
    endproperty
    a_pair_repeat: assert property (p_pair_repeat) else $error("repeat cleared");

    property p_short_delay;
        in_sleep && ext_reset_n && !cfg_crystal && wake_any
            |=> (!cpu_run) [*2] ##1 cpu_run;
    endproperty
    a_short_delay: assert property (p_short_delay) else $error("short delay wrong");

    property p_rst_wake;
        wake_rst |=> act.full_reset && state_q == wdw_pkg::WDW_DELAY;
    endproperty
    a_rst_wake: assert property (p_rst_wake) else $error("reset wake lost");

    property p_held_irq;
        halt_run |=> irq_held_q == $past(irq_req);
    endproperty
    a_held_irq: assert property (p_held_irq) else $error("held request lost");

    property p_reserved;
        setup_rd && !pwrite && paddr == `WDW_OFS_PERIOD |=> prdata_q[31:3] == 29'h0000_0000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits set");

    c_pair: cover property (cfg_pair_clear && clr_hit);
    c_take: cover property (act.take_irq);
    c_resume: cover property (act.resume);
    c_run_rst: cover property (wdt_reset);
endmodule : wdw_top
`default_nettype wire

//--- tb/watchdog_and_wakeup_control_test.sv
// Self-checking bench for the watchdog and wake-up block.
// Assumes the core model file and the design files are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "wdw_regs.svh"
module watchdog_and_wakeup_control_test;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cfg_wdt_en, cfg_pair_clear;
    logic cfg_crystal, low_speed_rc_osc_tick, stack_full, ext_reset_n, wdt_reset, cpu_run, req;
    logic timeout_flag, power_down_flag, tick_on;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] irq_req, irq_en, instr_w;
    logic [7:0] wake_port_pins;
    logic [1:0] req_kind;
    logic err;
    wdw_pkg::wdw_clk_src_t cfg_clk_src;
    wdw_pkg::wdw_act_t act;
    int miscompares = 0;
    int total_checks = 0;
    int cyc = 0;
    int rst_cnt = 0;
    int m_pdf = 0;
    int seed = 32'hc52c_eb96;
    ////////////////////////////////////////
    wdw_core_model i_core (.pclk(pclk), .presetn(presetn), .req(req), .req_kind(req_kind),
        .instr(instr_w));
    wdw_top #(.RST_DELAY_CYC(8)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cfg_wdt_en(cfg_wdt_en),
        .cfg_clk_src(cfg_clk_src), .cfg_pair_clear(cfg_pair_clear),
        .cfg_crystal(cfg_crystal), .lxt_tick(1'b0), .low_speed_rc_osc_tick(low_speed_rc_osc_tick),
        .instr(wdw_pkg::wdw_instr_t'(instr_w)), .irq_req(irq_req), .irq_en(irq_en),
        .stack_full(stack_full), .ext_reset_n(ext_reset_n),
        .wake_port_pins(wake_port_pins), .act(act), .wdt_reset(wdt_reset),
        .cpu_run(cpu_run), .timeout_flag(timeout_flag), .power_down_flag(power_down_flag));
    ////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // The slow clock ticks every other cycle, so one period is twice its tick count.
    always @(posedge pclk) begin
        low_speed_rc_osc_tick <= tick_on & ~low_speed_rc_osc_tick;
        if (wdt_reset === 1'b1) begin
            rst_cnt <= rst_cnt + 1;
        end
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            miscompares++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test
    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_word
    task automatic chk_act(input string nm, input wdw_pkg::wdw_act_t e,
        input wdw_pkg::wdw_act_t g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_act
    ////////////////////////////////////////
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Ready, read data and error are all taken at the edge that completes the access.
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (pready !== 1'b1) begin
            miscompares++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk_word("read data", e, rd);
    endtask : rd_chk
    task automatic instr_do(input int k);
        @(posedge pclk);
        req <= 1'b1;
        req_kind <= 2'(k);
        @(posedge pclk);
        req <= 1'b0;
        @(posedge pclk);
        #1;
    endtask : instr_do
    task automatic halt();
        instr_do(3);
        m_pdf = 1;
        chk_word("cpu_run", 0, cpu_run);
        chk_word("power_down_flag", m_pdf, power_down_flag);
    endtask : halt
    // Counts edges from the one that samples the source until the core runs again.
    task automatic wake_chk(input int len, input logic [3:0] ea);
        int n;
        wdw_pkg::wdw_act_t seen;
        n = 0;
        seen = '0;
        do begin
            @(posedge pclk);
            ext_reset_n <= 1'b1;
            #1;
            n++;
            seen = wdw_pkg::wdw_act_t'(seen | act);
        end while (cpu_run !== 1'b1 && n < 1500);
        if (cpu_run !== 1'b1) begin
            miscompares++;
        end
        if (len >= 0) begin
            chk_word("wake delay", len + 1, n);
        end
        chk_act("wake action", wdw_pkg::wdw_act_t'(ea), seen);
    endtask : wake_chk
    task automatic pin_wake(input int k, input int idle);
        apb(1'b1, `WDW_OFS_PORTWAKE, 32'h1 << k);
        halt();
        @(posedge pclk);
        wake_port_pins[(k + 1) % 8] <= 1'b0;
        repeat (idle) @(posedge pclk);
        #1;
        chk_word("asleep", 0, cpu_run);
        @(posedge pclk);
        wake_port_pins[k] <= 1'b0;
        wake_chk(2, 4'b0010);
        @(posedge pclk);
        wake_port_pins <= 8'hFF;
    endtask : pin_wake
    ////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, req, tick_on, low_speed_rc_osc_tick, stack_full} = '0;
        {cfg_wdt_en, cfg_pair_clear, cfg_crystal} = '0;
        {paddr, pwdata, irq_req, irq_en, req_kind} = '0;
        cfg_clk_src = wdw_pkg::WDW_SRC_LOW_SPEED_RC_OSC;
        ext_reset_n = 1'b1;
        wake_port_pins = 8'hFF;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(`WDW_OFS_PERIOD, 32'h0000_0007);
        rd_chk(`WDW_OFS_CTRL, 32'h0000_000A);
        rd_chk(`WDW_OFS_STATUS, 32'h0000_0000);
        rd_chk(12'h010, 32'h0000_0000);
        chk_word("slave error", 1, err);
        pin_wake($unsigned($random(seed)) % 8, 10);
        instr_do(0);
        chk_word("power_down_flag", m_pdf, power_down_flag);
        @(posedge pclk);
        irq_req <= 4'h1;
        pin_wake(3, 30);
        for (int i = 0; i < 3; i++) begin
            @(posedge pclk);
            irq_req <= 4'h0;
            irq_en <= (i == 1) ? 4'h0 : 4'h2;
            stack_full <= (i == 2);
            cfg_crystal <= (i == 0);
            halt();
            @(posedge pclk);
            irq_req <= 4'h2;
            wake_chk((i == 0) ? 128 : 2, (i == 0) ? 4'b0001 : 4'b0010);
        end
        @(posedge pclk);
        irq_req <= 4'h0;
        cfg_crystal <= 1'b0;
        halt();
        @(posedge pclk);
        ext_reset_n <= 1'b0;
        wake_chk(8 + 128, 4'b1000);
        apb(1'b1, `WDW_OFS_PERIOD, 32'h0000_00F8);
        rd_chk(`WDW_OFS_PERIOD, 32'h0000_0000);
        apb(1'b1, `WDW_OFS_CTRL, 32'h0000_0005);
        rd_chk(`WDW_OFS_STATUS, 32'h0000_0004 | (m_pdf << 1));
        tick_on <= 1'b1;
        instr_do(0);
        m_pdf = 0;
        chk_word("power_down_flag", m_pdf, power_down_flag);
        repeat (400) @(posedge pclk);
        instr_do(0);
        repeat (400) @(posedge pclk);
        chk_word("reset count", 0, rst_cnt);
        repeat (200) @(posedge pclk);
        chk_word("reset count", 1, rst_cnt);
        chk_word("timeout_flag", 1, timeout_flag);
        cfg_pair_clear <= 1'b1;
        instr_do(2);
        instr_do(1);
        repeat (300) @(posedge pclk);
        instr_do(1);
        repeat (150) @(posedge pclk);
        chk_word("reset count", 1, rst_cnt);
        repeat (100) @(posedge pclk);
        chk_word("reset count", 2, rst_cnt);
        halt();
        wake_chk(-1, 4'b0100);
        rd_chk(`WDW_OFS_STATUS, 32'h0000_0007);
        cfg_clk_src <= wdw_pkg::WDW_SRC_SYSDIV4;
        pin_wake(5, 1200);
        end_of_test();
    end
endmodule : watchdog_and_wakeup_control_test
`default_nettype wire

//--- tb/wdw_core_model.sv
// Processor core stand-in that turns bench requests into instruction pulses.
// Assumes requests change just after a rising edge and last one cycle each.
`timescale 1ns/1ns
`default_nettype none
module wdw_core_model (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Request from the bench: 0 clear, 1 first pair, 2 second pair, 3 halt.
    input wire logic req,
    input wire logic [1:0] req_kind,
    // Instruction pulses to the watchdog.
    output logic [3:0] instr
);
    // Only one pulse is ever high, so the pairing tracker sees distinct events.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr <= 4'h0;
        end else begin
            instr <= req ? (4'h8 >> req_kind) : 4'h0;
        end
    end
endmodule : wdw_core_model
`default_nettype wire
